// ==== hdl/full_loop_control_select.v ====
// Selects semi or fully closed loop control from configuration and requests.
// Assumes an APB master on mclk and request pins from outside the clock domain.
// What this block does
// - Linear motor mode with fully closed loop use raises parameter-error sub-code two.
// - Loop system select 0 means semi closed, 1 fully closed system.
// - Semi closed system: semi control, motor units, absolute allowed, requests ignored.
// - Full system, function 0: dual feedback always, absolute only with absolute encoder.
// - Full system, function 1: request off semi, on dual; no absolute detection.
// - Function select 0 is always full; 1 is switching by requests.
// - Switching mode: full if either request on, semi only if both off.
// - Unmapped local request input counts as permanently off.
// - Function select 1 with absolute enable 1 raises parameter error.
// - Function select honoured only while loop system select is 1.
// - Droop clear select 0 clears droop on each switch; 1 keeps it.
// - Fully closed system allowed only in position and positioning modes.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`include "loop_select_defs.vh"
module full_loop_control_select (
  input wire mclk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire host_full_loop_request,
  input wire input_full_loop_request,
  input wire droop_pulse,
  output reg [1:0] control_method,
  output reg load_side_units,
  output reg absolute_available,
  output reg droop_clear,
  output reg parameter_error_alarm,
  output reg [3:0] parameter_error_sub,
  output wire irq
);

  reg [`CFG_WIDTH-1:0] config_reg;
  wire [`EV_WIDTH-1:0] event_status;
  reg [`EV_WIDTH-1:0] event_enable;
  reg [15:0] droop_count;
  wire host_sync;
  wire input_sync;
  wire droop_sync;
  reg droop_prev;

  // Decoded configuration fields
  wire [3:0] motor_type_mode_field = config_reg[`CFG_MOTOR_MODE_MSB:`CFG_MOTOR_MODE_LSB];
  wire loop_system_select = config_reg[`CFG_LOOP_SYSTEM];
  wire loop_function_select = config_reg[`CFG_LOOP_FUNCTION];
  wire absolute_detect_enable = config_reg[`CFG_ABS_ENABLE];
  wire droop_clear_select = config_reg[`CFG_DROOP_CLEAR];
  wire input_mapped = config_reg[`CFG_INPUT_MAPPED];
  wire absolute_load_encoder = config_reg[`CFG_ABS_LOAD_ENC];
  wire position_mode = config_reg[`CFG_POS_MODE];

  // Read captured in setup, write in access: no wait state is ever inserted
  wire apb_write = psel & penable & pwrite;
  wire apb_read = psel & ~penable & ~pwrite;
  wire apb_access = psel & penable;

  // Zero-wait slave; unmapped addresses answer with an error
  wire sel_config = (paddr == `ADDR_CONFIG);
  wire sel_status = (paddr == `ADDR_STATUS);
  wire sel_event = (paddr == `ADDR_EVENT);
  wire sel_event_clear = (paddr == `ADDR_EVENT_CLEAR);
  wire sel_event_enable = (paddr == `ADDR_EVENT_ENABLE);
  wire sel_droop_count = (paddr == `ADDR_DROOP_COUNT);
  wire addr_mapped = sel_config | sel_status | sel_event | sel_event_clear | sel_event_enable | sel_droop_count;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_mapped;

  // Request and droop pins come from outside; two flops before any logic
  bit_sync #(.IDLE_LEVEL(1'b0)) i_host_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(host_full_loop_request),
    .sync_out(host_sync)
  );

  bit_sync #(.IDLE_LEVEL(1'b0)) i_input_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(input_full_loop_request),
    .sync_out(input_sync)
  );

  bit_sync #(.IDLE_LEVEL(1'b0)) i_droop_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(droop_pulse),
    .sync_out(droop_sync)
  );

  // Previous droop level; idle low, so no false edge after reset
  always @(posedge mclk) begin
    if (reset) begin
      droop_prev <= 1'b0;
    end else begin
      droop_prev <= droop_sync;
    end
  end

  // Combined selection, resolved in one step so no mixed method is ever seen
  localparam SEL_SEMI_SYSTEM = 4'b0001;
  localparam SEL_FULL_ALWAYS = 4'b0010;
  localparam SEL_SWITCHED = 4'b0100;
  localparam SEL_REFUSED = 4'b1000;

  reg [3:0] selection;
  reg [1:0] next_method;
  reg next_load_units;
  reg next_absolute;
  reg next_alarm;
  reg [3:0] next_sub;
  // Requests and the three parameter conflicts
  wire local_request = input_mapped & input_sync;
  wire switch_request = host_sync | local_request;
  wire linear_conflict = loop_system_select & (motor_type_mode_field == `MOTOR_LINEAR);
  wire abs_conflict = loop_system_select & loop_function_select & absolute_detect_enable;
  wire mode_conflict = loop_system_select & ~position_mode;

  // Which row of the selection table applies
  always @* begin
    if (!loop_system_select) begin
      selection = SEL_SEMI_SYSTEM;
    end else if (mode_conflict) begin
      selection = SEL_REFUSED;
    end else if (!loop_function_select) begin
      selection = SEL_FULL_ALWAYS;
    end else begin
      selection = SEL_SWITCHED;
    end
  end

  // Outputs of each row; function select and requests matter only when switched
  always @* begin
    case (selection)
      SEL_SEMI_SYSTEM: begin
        next_method = `METHOD_SEMI;
        next_load_units = 1'b0;
        next_absolute = 1'b1;
      end
      SEL_FULL_ALWAYS: begin
        next_method = `METHOD_FULL;
        next_load_units = 1'b1;
        next_absolute = absolute_load_encoder;
      end
      SEL_SWITCHED: begin
        next_method = switch_request ? `METHOD_FULL : `METHOD_SEMI;
        next_load_units = 1'b1;
        next_absolute = 1'b0;
      end
      SEL_REFUSED: begin
        // Fully closed refused outside position modes; fall back to the semi system
        next_method = `METHOD_SEMI;
        next_load_units = 1'b0;
        next_absolute = 1'b1;
      end
      default: begin
        next_method = `METHOD_SEMI;
        next_load_units = 1'b0;
        next_absolute = 1'b1;
      end
    endcase
  end

  // Alarm sub-code priority: linear conflict, then mode, then absolute
  always @* begin
    next_alarm = 1'b0;
    next_sub = `SUB_NONE;
    if (linear_conflict) begin
      next_alarm = 1'b1;
      next_sub = `SUB_LINEAR;
    end else if (mode_conflict) begin
      next_alarm = 1'b1;
      next_sub = `SUB_MODE;
    end else if (abs_conflict) begin
      next_alarm = 1'b1;
      next_sub = `SUB_ABS;
    end
  end

  // Seen before the register moves, so clear and event align with the new method
  wire method_change = (next_method != control_method);
  wire clear_on_switch = method_change & ~droop_clear_select;

  // Method, units and absolute permission move together in one edge
  always @(posedge mclk) begin
    if (reset) begin
      control_method <= `METHOD_SEMI;
      load_side_units <= 1'b0;
      absolute_available <= 1'b1;
    end else begin
      control_method <= next_method;
      load_side_units <= next_load_units;
      absolute_available <= next_absolute;
    end
  end

  // Alarm is a live level; the latched record is the event bit
  always @(posedge mclk) begin
    if (reset) begin
      parameter_error_alarm <= 1'b0;
      parameter_error_sub <= `SUB_NONE;
    end else begin
      parameter_error_alarm <= next_alarm;
      parameter_error_sub <= next_sub;
    end
  end

  // One-cycle pulse per switch; none when droop is kept across a switch
  always @(posedge mclk) begin
    if (reset) begin
      droop_clear <= 1'b0;
    end else begin
      droop_clear <= clear_on_switch;
    end
  end

  // Accumulated droop pulses; cleared on a switch when clearing is enabled
  // Saturates rather than wraps, so a long run never reads back as a small count
  wire droop_rise = droop_sync & ~droop_prev;
  always @(posedge mclk) begin
    if (reset) begin
      droop_count <= `DROOP_RESET;
    end else if (clear_on_switch) begin
      droop_count <= `DROOP_RESET;
    end else if (droop_rise && droop_count != `DROOP_MAX) begin
      droop_count <= droop_count + 16'h0001;
    end
  end

  // Configuration register
  always @(posedge mclk) begin
    if (reset) begin
      config_reg <= `CFG_RESET;
    end else if (apb_write && sel_config) begin
      config_reg <= pwdata[`CFG_WIDTH-1:0];
    end
  end

  // Enable register, same layout as the status
  always @(posedge mclk) begin
    if (reset) begin
      event_enable <= `EV_RESET;
    end else if (apb_write && sel_event_enable) begin
      event_enable <= pwdata[`EV_WIDTH-1:0];
    end
  end

  // Sticky events; a set in the clearing cycle wins
  wire [`EV_WIDTH-1:0] event_set = {next_alarm & ~parameter_error_alarm, method_change};
  wire [`EV_WIDTH-1:0] event_clr = (apb_write && sel_event_clear) ? pwdata[`EV_WIDTH-1:0] : `EV_RESET;
  genvar ev;
  generate
    for (ev = 0; ev < `EV_WIDTH; ev = ev + 1) begin : g_event
      sticky_flag i_sticky_flag (
        .mclk(mclk),
        .reset(reset),
        .set_in(event_set[ev]),
        .clear_in(event_clr[ev]),
        .flag(event_status[ev])
      );
    end
  endgenerate

  // Level, not pulse: it stays up until software clears the event
  assign irq = |(event_status & event_enable);

  // Read mux; the clear register is write-only and reads as zero
  reg [31:0] next_prdata;
  always @* begin
    case (paddr)
      `ADDR_CONFIG: next_prdata = {21'h0, config_reg};
      `ADDR_STATUS: next_prdata = {24'h0, parameter_error_sub, absolute_available, load_side_units, control_method};
      `ADDR_EVENT: next_prdata = {30'h0, event_status};
      `ADDR_EVENT_ENABLE: next_prdata = {30'h0, event_enable};
      `ADDR_DROOP_COUNT: next_prdata = {16'h0, droop_count};
      default: next_prdata = 32'h0;
    endcase
  end

  // Read data registered in the setup cycle, valid in the access cycle
  always @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (apb_read) begin
      prdata <= next_prdata;
    end
  end

endmodule

// Two-flop synchroniser for a level from outside the mclk domain
// Pulses shorter than one cycle may be lost
module bit_sync #(
  parameter IDLE_LEVEL = 1'b0
) (
  input wire mclk,
  input wire reset,
  input wire async_in,
  output reg sync_out
);

  reg meta;

  // Only sync_out may be read outside; meta can be metastable
  always @(posedge mclk) begin
    if (reset) begin
      meta <= IDLE_LEVEL;
      sync_out <= IDLE_LEVEL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// Sticky status bit: a set in the same cycle as a clear wins
// Clear is a one-cycle strobe from a register write
module sticky_flag (
  input wire mclk,
  input wire reset,
  input wire set_in,
  input wire clear_in,
  output reg flag
);

  always @(posedge mclk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_in) begin
      flag <= 1'b1;
    end else if (clear_in) begin
      flag <= 1'b0;
    end
  end

endmodule

// ==== hdl/loop_select_defs.vh ====
// Constants for the loop control selection block.
// Assumes inclusion by bare name from the design file.
`ifndef LOOP_SELECT_DEFS_VH
`define LOOP_SELECT_DEFS_VH
// APB register byte addresses
`define ADDR_CONFIG 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_EVENT 12'h008
`define ADDR_EVENT_CLEAR 12'h00c
`define ADDR_EVENT_ENABLE 12'h010
`define ADDR_DROOP_COUNT 12'h014
// Config field positions
`define CFG_MOTOR_MODE_LSB 0
`define CFG_MOTOR_MODE_MSB 3
`define CFG_LOOP_SYSTEM 4
`define CFG_LOOP_FUNCTION 5
`define CFG_ABS_ENABLE 6
`define CFG_DROOP_CLEAR 7
`define CFG_INPUT_MAPPED 8
`define CFG_ABS_LOAD_ENC 9
`define CFG_POS_MODE 10
`define CFG_WIDTH 11
`define CFG_RESET 11'h000
// Motor type mode values
`define MOTOR_STANDARD 4'h0
`define MOTOR_LINEAR 4'h4
// Control method codes
`define METHOD_SEMI 2'h1
`define METHOD_FULL 2'h2
// Event bits
`define EV_SWITCH 0
`define EV_ALARM 1
`define EV_WIDTH 2
`define EV_RESET 2'h0
`define DROOP_RESET 16'h0000
`define DROOP_MAX 16'hffff
// Parameter-error sub-codes
`define SUB_NONE 4'h0
`define SUB_ABS 4'h1
`define SUB_LINEAR 4'h2
`define SUB_MODE 4'h3
`endif

// ==== verif/loop_select_properties.sv ====
// Port-level properties of the loop selection block.
// Assumes one clock, mclk, and a synchronous active-high reset.
`include "loop_select_defs.vh"
module loop_select_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic [1:0] control_method,
  input wire logic load_side_units,
  input wire logic absolute_available,
  input wire logic droop_clear,
  input wire logic parameter_error_alarm,
  input wire logic [3:0] parameter_error_sub
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_changed;
    control_method != $past(control_method);
  endsequence
  sequence s_one_cycle;
    droop_clear ##1 !droop_clear;
  endsequence
  property p_method;
    control_method == `METHOD_SEMI || control_method == `METHOD_FULL;
  endproperty
  property p_full_units;
    control_method == `METHOD_FULL |-> load_side_units;
  endproperty
  property p_semi_system;
    !load_side_units |-> control_method == `METHOD_SEMI;
  endproperty
  property p_semi_abs;
    !load_side_units && parameter_error_sub == 4'h0 |-> absolute_available;
  endproperty
  property p_switch_abs;
    load_side_units && control_method == `METHOD_SEMI |-> !absolute_available;
  endproperty
  property p_alarm;
    parameter_error_alarm == (parameter_error_sub != 4'h0);
  endproperty
  property p_droop_cause;
    droop_clear |-> s_changed;
  endproperty
  property p_droop_pulse;
    droop_clear |-> s_one_cycle;
  endproperty
  property p_slverr;
    pslverr |-> psel && penable;
  endproperty
  a_method: assert property (p_method) else $error("bad method code");
  a_full_units: assert property (p_full_units) else $error("full without load units");
  a_semi_system: assert property (p_semi_system) else $error("motor units not semi");
  a_semi_abs: assert property (p_semi_abs) else $error("semi without absolute");
  a_switch_abs: assert property (p_switch_abs) else $error("absolute while switching");
  a_alarm: assert property (p_alarm) else $error("alarm and sub disagree");
  a_droop_cause: assert property (p_droop_cause) else $error("clear without switch");
  a_droop_pulse: assert property (p_droop_pulse) else $error("clear longer than a cycle");
  a_slverr: assert property (p_slverr) else $error("error outside access");
endmodule
bind full_loop_control_select loop_select_properties i_props (.mclk, .reset, .psel, .penable, .pslverr,
  .control_method, .load_side_units, .absolute_available, .droop_clear, .parameter_error_alarm,
  .parameter_error_sub);

// ==== verif/request_source.sv ====
// Motion controller and local input device giving the switching requests.
// Assumes the bench sets the wanted levels; outputs move just after mclk.
module request_source (
  input wire logic mclk,
  input wire logic host_set,
  input wire logic input_set,
  output logic host_full_loop_request = 1'b0,
  output logic input_full_loop_request = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels held for many cycles; short pulses would be lost in the sync
  always @(posedge mclk) begin
    host_full_loop_request <= host_set;
    input_full_loop_request <= input_set;
  end
endmodule

// ==== verif/testbench.sv ====
// Bench: APB and request sequences against the loop selection block.
// Assumes hdl/ on the include path and the other verif files compiled first.
`include "loop_select_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, droop_pulse = 0, hs = 0, ls = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr, host_full_loop_request, input_full_loop_request, droop_clear, irq;
  logic load_side_units, absolute_available, parameter_error_alarm;
  logic [1:0] control_method;
  logic [3:0] parameter_error_sub;
  logic [31:0] cfg [9] = '{12'h400, 12'h410, 12'h610, 12'h430, 12'h470, 12'h414, 12'h460, 12'h010, 12'h404};
  logic [31:0] exs [9] = '{8'h09, 8'h06, 8'h0e, 8'h05, 8'h15, 8'h26, 8'h09, 8'h39, 8'h09};
  int bad_count = 0, n_checks = 0;
  initial forever #50 mclk = ~mclk;
  full_loop_control_select i_full_loop_control_select (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .host_full_loop_request, .input_full_loop_request, .droop_pulse, .control_method,
    .load_side_units, .absolute_available, .droop_clear, .parameter_error_alarm, .parameter_error_sub, .irq);
  request_source i_request_source (.mclk, .host_set(hs), .input_set(ls), .host_full_loop_request,
    .input_full_loop_request);
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      conclude();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    bus(0, a, 0);
    cmp($sformatf("reg %h", a), e, rdv);
  endtask
  task automatic req(logic h, logic l);
    hs <= h;
    ls <= l;
    repeat (6) @(posedge mclk);
  endtask
  task automatic pulses(int n);
    repeat (n) begin
      droop_pulse <= 1;
      repeat (3) @(posedge mclk);
      droop_pulse <= 0;
      repeat (3) @(posedge mclk);
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    rd(`ADDR_CONFIG, 0);
    rd(`ADDR_STATUS, 32'h09);
    for (int i = 0; i < 9; i++) begin
      bus(1, `ADDR_CONFIG, cfg[i]);
      rd(`ADDR_STATUS, exs[i]);
    end
    bus(1, `ADDR_EVENT_ENABLE, 3);
    bus(1, `ADDR_CONFIG, 32'h530);
    pulses(3);
    rd(`ADDR_DROOP_COUNT, 3);
    req(1, 0);
    rd(`ADDR_STATUS, 32'h06);
    rd(`ADDR_DROOP_COUNT, 0);
    rd(`ADDR_EVENT, 3);
    cmp("irq", 1, irq);
    bus(1, `ADDR_EVENT_CLEAR, 3);
    rd(`ADDR_EVENT, 0);
    cmp("irq", 0, irq);
    req(0, 1);
    rd(`ADDR_STATUS, 32'h06);
    req(0, 0);
    rd(`ADDR_STATUS, 32'h05);
    bus(1, `ADDR_CONFIG, 32'h4b0);
    req(0, 1);
    rd(`ADDR_STATUS, 32'h05);
    pulses(2);
    req(1, 0);
    rd(`ADDR_DROOP_COUNT, 2);
    bus(1, 12'h018, 5);
    cmp("pslverr", 1, err);
    rd(12'h018, 0);
    conclude();
  end
endmodule
